// [inc/crt_map_pkg.sv]
`default_nettype none

package crt_map_pkg;

   // Indexed I/O ports, mono and colour decodes
   localparam logic [15:0] PORT_INDEX_MONO  = 16'h03B4;
   localparam logic [15:0] PORT_DATA_MONO   = 16'h03B5;
   localparam logic [15:0] PORT_INDEX_COLOR = 16'h03D4;
   localparam logic [15:0] PORT_DATA_COLOR  = 16'h03D5;

   // Index of the mode control register
   localparam logic [7:0]  IDX_CRT_MODE_CONTROL = 8'h17;

   // Field positions in crt_mode_control
   localparam int BIT_CTRL_RESET   = 7;
   localparam int BIT_WORD_BYTE    = 6;
   localparam int BIT_ADDR_WRAP    = 5;
   localparam int BIT_RESERVED     = 4;
   localparam int BIT_COUNT_BY_2   = 3;
   localparam int BIT_HRETRACE_SEL = 2;
   localparam int BIT_ROW_SCAN_SEL = 1;
   localparam int BIT_COMPAT_SUPP  = 0;

   // Field positions in underline_location_reg, owned elsewhere
   localparam int BIT_UL_DWORD     = 6;
   localparam int BIT_UL_COUNT_BY4 = 5;

   // Reset value and readable bits of crt_mode_control
   localparam logic [7:0]  CRT_MODE_RESET   = 8'h00;
   localparam logic [7:0]  INDEX_RESET      = 8'h00;
   localparam logic [7:0]  CRT_MODE_RD_MASK = 8'hEF;
   localparam logic [7:0]  RDATA_IDLE       = 8'h00;

   // Decoder input bits that may carry row scan bits
   localparam int ADDR_W          = 16;
   localparam int SUBST_BIT_RS0   = 13;
   localparam int SUBST_BIT_RS1   = 14;
   localparam int ROW_SCAN_W      = 5;

   // Interval counter limits
   localparam logic [1:0]  DIV_LAST_1 = 2'h0;
   localparam logic [1:0]  DIV_LAST_2 = 2'h1;
   localparam logic [1:0]  DIV_LAST_4 = 2'h3;
   localparam logic [1:0]  PHASE_ZERO = 2'h0;

   typedef enum logic [1:0] {
      DIV_BY_1,
      DIV_BY_2,
      DIV_BY_4
   } div_ratio_t;

   typedef enum logic [1:0] {
      MODE_BYTE,
      MODE_WORD_WRAP,
      MODE_WORD_NOWRAP,
      MODE_DWORD
   } addr_mode_t;

endpackage : crt_map_pkg

`default_nettype wire

// [rtl/event_divider.sv]
`timescale 1ns/100ps
`default_nettype none

module event_divider (
   input  wire logic                    clk_sys_in,  // System clock
   input  wire logic                    srst_in,     // Sync reset
   input  wire logic                    event_in,    // One-cycle source event
   input  wire logic                    resync_in,   // Realign phase to zero
   input  wire crt_map_pkg::div_ratio_t ratio_in,    // Division ratio
   output logic                         tick_out     // One-cycle divided event
);

   logic [1:0] count_reg;
   logic [1:0] count_next;
   logic [1:0] last;
   logic       at_last;

   assign last = (ratio_in == crt_map_pkg::DIV_BY_4) ? crt_map_pkg::DIV_LAST_4 :
                 (ratio_in == crt_map_pkg::DIV_BY_2) ? crt_map_pkg::DIV_LAST_2 :
                                                       crt_map_pkg::DIV_LAST_1;
   // Greater-or-equal so a ratio lowered mid-count still ticks at once
   assign at_last    = (count_reg >= last);
   assign tick_out   = event_in && at_last;
   assign count_next = resync_in ? crt_map_pkg::PHASE_ZERO :
                       !event_in ? count_reg :
                       at_last   ? crt_map_pkg::PHASE_ZERO : 2'(count_reg + 2'h1);

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         count_reg <= crt_map_pkg::PHASE_ZERO;
      end else begin
         count_reg <= count_next;
      end
   end

endmodule : event_divider

`default_nettype wire

// [rtl/addr_reorganizer.sv]
`timescale 1ns/100ps
`default_nettype none

module addr_reorganizer (
   input  wire logic [15:0]             ma_count_in,              // Memory address counter
   input  wire crt_map_pkg::addr_mode_t mode_in,                  // Addressing mode
   input  wire logic                    row_scan_sel_in,          // 0 puts row scan bit 1 on 14
   input  wire logic                    compat_sel_in,            // 0 puts row scan bit 0 on 13
   input  wire logic [1:0]              row_scan_out_in,          // Row scan counter bits 1:0
   output logic      [15:0]             reorganized_address_out,  // Shifted counter address
   output logic      [15:0]             decoder_address_in_out    // Address to frame buffer decoder
);

   function automatic logic [15:0] reorganize(input logic [15:0] ma,
                                              input crt_map_pkg::addr_mode_t mode);
      logic [15:0] r;
      r = ma;
      unique case (mode)
         crt_map_pkg::MODE_BYTE:        r = ma;                     // RQ6
         crt_map_pkg::MODE_WORD_NOWRAP: r = {ma[14:0], ma[15]};     // RQ7
         crt_map_pkg::MODE_WORD_WRAP:   r = {ma[14:0], ma[13]};     // RQ8
         crt_map_pkg::MODE_DWORD:       r = {ma[13:0], ma[13:12]};  // RQ9
      endcase
      return r;
   endfunction : reorganize

   // Pure logic: a control change shows on the very next address
   assign reorganized_address_out = reorganize(ma_count_in, mode_in);  // RQ14

   // Substitution acts on the reorganized bits, never the raw count
   always_comb begin
      decoder_address_in_out = reorganized_address_out;  // RQ5 RQ10
      if (!compat_sel_in) begin
         decoder_address_in_out[crt_map_pkg::SUBST_BIT_RS0] = row_scan_out_in[0];  // RQ4
      end
      if (!row_scan_sel_in) begin
         decoder_address_in_out[crt_map_pkg::SUBST_BIT_RS1] = row_scan_out_in[1];  // RQ3
      end
   end

endmodule : addr_reorganizer

`default_nettype wire

// [rtl/crt_refresh_address_mapper.sv]
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// RQ1: Counter advance interval from count-by-4, count-by-2 bits
// RQ2: Retrace select halves vertical counter clock
// RQ3: Row scan select 0 puts scan bit1 on 14
// RQ4: Compat bit 0 puts scan bit0 on 13
// RQ5: Substitution follows word/doubleword reorganization
// RQ6: Byte mode passes counter bits unchanged
// RQ7: Word no-wrap rotates bit 15 to bit 0
// RQ8: Word wrap brings bit 13 to bit 0
// RQ9: Doubleword maps 12,13 to 0,1, shift two
// RQ10: Bits 0-12 and 15 pass straight through
// RQ11: Don't-care control bits leave mapping unchanged
// RQ12: Wrap bit wraps at 16KB, word mode only
// RQ13: Index 17h through CRT index and data ports
// RQ14: Mapping is combinational from current inputs
module crt_refresh_address_mapper (
   input  wire logic        clk_sys_in,               // System clock, 250 MHz
   input  wire logic        srst_in,                  // Sync reset, active high
   // Indexed I/O access
   input  wire logic [15:0] io_addr_in,               // I/O port address
   input  wire logic        io_wr_in,                 // Write strobe, one cycle
   input  wire logic        io_rd_in,                 // Read strobe, one cycle
   input  wire logic [7:0]  io_wdata_in,              // Write data
   input  wire logic        io_color_sel_in,          // 1 selects colour ports, 0 mono
   output logic      [7:0]  io_rdata_out,             // Read data, registered
   output logic             io_ack_out,               // Claimed access done, one cycle
   // Underline location fields kept elsewhere
   input  wire logic        ul_dword_mode_in,         // Doubleword mode bit
   input  wire logic        ul_count_by_4_in,         // Count by 4 bit
   // Timing events
   input  wire logic        char_clk_in,              // Character clock strobe
   input  wire logic        hretrace_in,              // Horizontal retrace strobe
   input  wire logic        frame_start_in,           // Realigns both dividers
   output logic             ma_advance_out,           // Advance memory address counter
   output logic             vcount_clk_out,           // Clock vertical timing counter
   // Refresh address path
   input  wire logic [15:0] ma_count_in,              // Memory address counter value
   input  wire logic [4:0]  row_scan_in,              // Row scan counter value
   output logic      [15:0] reorganized_address_out,  // Reorganized counter address
   output logic      [15:0] decoder_address_in_out,   // Frame buffer decoder address
   // Status and controls for neighbours
   output logic      [7:0]  crt_mode_control_out,     // Register contents
   output logic             crt_ctrl_run_out,         // Sync enable, 0 holds syncs off
   output logic      [1:0]  addr_mode_out             // Current addressing mode code
);

   logic [7:0] index_reg;
   logic [7:0] index_next;
   logic [7:0] crt_mode_control_reg;
   logic [7:0] crt_mode_control_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       ack_reg;
   logic       ack_next;

   // Port decode
   logic [15:0] port_index;
   logic [15:0] port_data;
   logic        hit_index;
   logic        hit_data;
   logic        sel_mode_reg;
   logic        wr_index;
   logic        wr_mode;
   logic        rd_any;

   assign port_index   = io_color_sel_in ? crt_map_pkg::PORT_INDEX_COLOR
                                         : crt_map_pkg::PORT_INDEX_MONO;
   assign port_data    = io_color_sel_in ? crt_map_pkg::PORT_DATA_COLOR
                                         : crt_map_pkg::PORT_DATA_MONO;
   assign hit_index    = (io_addr_in == port_index);  // RQ13
   assign hit_data     = (io_addr_in == port_data);   // RQ13
   assign sel_mode_reg = (index_reg == crt_map_pkg::IDX_CRT_MODE_CONTROL);  // RQ13
   assign wr_index     = io_wr_in && hit_index;
   assign wr_mode      = io_wr_in && hit_data && sel_mode_reg;
   assign rd_any       = io_rd_in && (hit_index || hit_data);

   // Other indices belong to sibling register blocks; the data port is
   // still acknowledged so the bus never hangs, reading idle data
   assign index_next            = wr_index ? io_wdata_in : index_reg;
   assign crt_mode_control_next = wr_mode ? io_wdata_in : crt_mode_control_reg;
   assign rdata_next            = !rd_any             ? rdata_reg :
                                  hit_index           ? index_reg :
                                  sel_mode_reg        ? (crt_mode_control_reg & crt_map_pkg::CRT_MODE_RD_MASK) :
                                                        crt_map_pkg::RDATA_IDLE;
   assign ack_next              = rd_any || (io_wr_in && (hit_index || hit_data));

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         index_reg            <= crt_map_pkg::INDEX_RESET;
         crt_mode_control_reg <= crt_map_pkg::CRT_MODE_RESET;
         rdata_reg            <= crt_map_pkg::RDATA_IDLE;
         ack_reg              <= 1'b0;
      end else begin
         index_reg            <= index_next;
         crt_mode_control_reg <= crt_mode_control_next;
         rdata_reg            <= rdata_next;
         ack_reg              <= ack_next;
      end
   end

   assign io_rdata_out         = rdata_reg;
   assign io_ack_out           = ack_reg;
   assign crt_mode_control_out = crt_mode_control_reg;
   assign crt_ctrl_run_out     = crt_mode_control_reg[crt_map_pkg::BIT_CTRL_RESET];

   // Control fields
   logic word_byte;
   logic addr_wrap;
   logic count_by_2;
   logic hretrace_sel;
   logic row_scan_sel;
   logic compat_supp;

   assign word_byte    = crt_mode_control_reg[crt_map_pkg::BIT_WORD_BYTE];
   assign addr_wrap    = crt_mode_control_reg[crt_map_pkg::BIT_ADDR_WRAP];
   assign count_by_2   = crt_mode_control_reg[crt_map_pkg::BIT_COUNT_BY_2];
   assign hretrace_sel = crt_mode_control_reg[crt_map_pkg::BIT_HRETRACE_SEL];
   assign row_scan_sel = crt_mode_control_reg[crt_map_pkg::BIT_ROW_SCAN_SEL];
   assign compat_supp  = crt_mode_control_reg[crt_map_pkg::BIT_COMPAT_SUPP];

   // Addressing mode; doubleword ignores word/byte and wrap, byte ignores wrap
   crt_map_pkg::addr_mode_t addr_mode;

   assign addr_mode = ul_dword_mode_in ? crt_map_pkg::MODE_DWORD :        // RQ11
                      word_byte        ? crt_map_pkg::MODE_BYTE :         // RQ11
                      !addr_wrap       ? crt_map_pkg::MODE_WORD_WRAP :    // RQ12
                                         crt_map_pkg::MODE_WORD_NOWRAP;   // RQ12
   assign addr_mode_out = addr_mode;

   // Character clock interval: count-by-2 wins over count-by-4
   crt_map_pkg::div_ratio_t char_ratio;

   assign char_ratio = count_by_2       ? crt_map_pkg::DIV_BY_2 :  // RQ1
                       ul_count_by_4_in ? crt_map_pkg::DIV_BY_4 :  // RQ1
                                          crt_map_pkg::DIV_BY_1;   // RQ1

   event_divider u_char_div (
      .clk_sys_in (clk_sys_in),
      .srst_in    (srst_in),
      .event_in   (char_clk_in),
      .resync_in  (frame_start_in),
      .ratio_in   (char_ratio),
      .tick_out   (ma_advance_out)
   );

   // Vertical clock; phase realigned each frame so line pairs stay fixed
   crt_map_pkg::div_ratio_t vert_ratio;

   assign vert_ratio = hretrace_sel ? crt_map_pkg::DIV_BY_2 : crt_map_pkg::DIV_BY_1;  // RQ2

   event_divider u_vert_div (
      .clk_sys_in (clk_sys_in),
      .srst_in    (srst_in),
      .event_in   (hretrace_in),
      .resync_in  (frame_start_in),
      .ratio_in   (vert_ratio),
      .tick_out   (vcount_clk_out)
   );

   // Address path is pure logic, no register stage in the way
   addr_reorganizer u_reorg (
      .ma_count_in             (ma_count_in),
      .mode_in                 (addr_mode),
      .row_scan_sel_in         (row_scan_sel),
      .compat_sel_in           (compat_supp),
      .row_scan_out_in         (row_scan_in[1:0]),
      .reorganized_address_out (reorganized_address_out),
      .decoder_address_in_out  (decoder_address_in_out)
   );

endmodule : crt_refresh_address_mapper

`default_nettype wire

// [sim/crt_map_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module crt_map_checker (
   input wire logic        clk_sys_in,              // Clock
   input wire logic        srst_in,                 // Reset
   input wire logic [15:0] io_addr_in,              // Port
   input wire logic        io_wr_in,                // Write
   input wire logic        io_rd_in,                // Read
   input wire logic [7:0]  io_wdata_in,             // Data
   input wire logic        io_color_sel_in,         // Decode
   input wire logic        io_ack_out,              // Ack
   input wire logic        ul_dword_mode_in,        // Dword
   input wire logic        ul_count_by_4_in,        // By 4
   input wire logic        char_clk_in,             // Char
   input wire logic        hretrace_in,             // Retrace
   input wire logic        ma_advance_out,          // Advance
   input wire logic        vcount_clk_out,          // Vertical
   input wire logic [15:0] ma_count_in,             // Counter
   input wire logic [4:0]  row_scan_in,             // Scan
   input wire logic [15:0] reorganized_address_out, // Shifted
   input wire logic [15:0] decoder_address_in_out,  // Decoder
   input wire logic [7:0]  crt_mode_control_out     // Register
);
   logic [7:0] idx_reg;
   wire logic hit_ix = io_addr_in == (io_color_sel_in ? 16'h03D4 : 16'h03B4);
   wire logic hit_dt = io_addr_in == (io_color_sel_in ? 16'h03D5 : 16'h03B5);
   wire logic dw = ul_dword_mode_in;
   wire logic [7:0] c = crt_mode_control_out;
   wire logic [15:0] m = ma_count_in;
   wire logic [15:0] r = reorganized_address_out;
   always_ff @(posedge clk_sys_in)
      if (srst_in) idx_reg <= 8'h00;
      else if (io_wr_in && hit_ix) idx_reg <= io_wdata_in;
   default clocking dcb @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);
   AST_ACK: assert property (io_ack_out == $past((io_wr_in || io_rd_in) && (hit_ix || hit_dt) && !srst_in))
      else $error("ack does not follow claimed access");
   AST_WRITE: assert property (io_wr_in && hit_dt && idx_reg == 8'h17 |=> c == $past(io_wdata_in))
      else $error("mode register write lost");
   AST_BYTE: assert property (!dw && c[6] |-> r == m)
      else $error("byte mode mapping");
   AST_WNOWRAP: assert property (!dw && !c[6] && c[5] |-> r == {m[14:0], m[15]})
      else $error("word mode mapping without wrap");
   AST_WWRAP: assert property (!dw && !c[6] && !c[5] |-> r == {m[14:0], m[13]})
      else $error("word mode mapping with wrap");
   AST_DWORD: assert property (dw |-> r == {m[13:0], m[13], m[12]})
      else $error("doubleword mapping");
   AST_SUBST: assert property (decoder_address_in_out == {r[15], c[1] ? r[14] : row_scan_in[1],
                               c[0] ? r[13] : row_scan_in[0], r[12:0]})
      else $error("row scan substitution");
   AST_ADV1: assert property (char_clk_in && !ul_count_by_4_in && !c[3] |-> ma_advance_out)
      else $error("advance missed at interval one");
   AST_VCLK: assert property (!c[2] |-> vcount_clk_out == hretrace_in)
      else $error("vertical clock not undivided");
endmodule : crt_map_checker
bind crt_refresh_address_mapper crt_map_checker u_chk (.clk_sys_in, .srst_in, .io_addr_in, .io_wr_in,
   .io_rd_in, .io_wdata_in, .io_color_sel_in, .io_ack_out, .ul_dword_mode_in, .ul_count_by_4_in, .char_clk_in,
   .hretrace_in, .ma_advance_out, .vcount_clk_out, .ma_count_in, .row_scan_in, .reorganized_address_out,
   .decoder_address_in_out, .crt_mode_control_out);
`default_nettype wire

// [sim/crt_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
module crt_far_model (
   input  wire logic        clk_sys_in,   // Clock
   input  wire logic        srst_in,      // Reset
   input  wire logic        advance_in,   // Address advance
   input  wire logic        vclk_in,      // Vertical tick
   input  wire logic        load_in,      // Load both counters
   input  wire logic [15:0] load_val_in,  // Address load value
   input  wire logic [4:0]  scan_val_in,  // Scan load value
   output logic      [15:0] ma_count_out, // Address counter
   output logic      [4:0]  row_scan_out  // Row scan counter
);
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         ma_count_out <= 16'h0000;
         row_scan_out <= 5'h00;
      end else if (load_in) begin
         ma_count_out <= load_val_in;
         row_scan_out <= scan_val_in;
      end else begin
         ma_count_out <= ma_count_out + {15'h0000, advance_in};
         row_scan_out <= row_scan_out + {4'h0, vclk_in};
      end
   end
endmodule : crt_far_model
`default_nettype wire

// [sim/crt_refresh_address_mapper_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module crt_refresh_address_mapper_tb_top;
   localparam logic [15:0] IXP = crt_map_pkg::PORT_INDEX_COLOR;
   localparam logic [15:0] DTP = crt_map_pkg::PORT_DATA_COLOR;
   logic clk_sys_in = 1'b0, srst_in = 1'b1, io_wr_in = 1'b0, io_rd_in = 1'b0, io_color_sel_in = 1'b0;
   logic ul_dword_mode_in = 1'b0, ul_count_by_4_in = 1'b0, char_clk_in = 1'b0, hretrace_in = 1'b0;
   logic frame_start_in = 1'b0, load_in = 1'b0, io_ack_out, ma_advance_out, vcount_clk_out, crt_ctrl_run_out;
   logic [15:0] io_addr_in = 16'h0000, load_val_in = 16'h0000, ma_count_in, reorganized_address_out;
   logic [15:0] decoder_address_in_out;
   logic [7:0]  io_wdata_in = 8'h00, io_rdata_out, crt_mode_control_out, rd_val, cv;
   logic [4:0]  row_scan_in, scan_val_in = 5'h00;
   logic [1:0]  addr_mode_out;
   logic [31:0] seed = 32'h0000_55A8;
   logic [15:0] corner [4] = '{16'h8000, 16'h2000, 16'h4000, 16'h1000};
   int          fail_count = 0, cmp_count = 0, na, nv;
   always #2 clk_sys_in = ~clk_sys_in;
   crt_refresh_address_mapper u_dut (.clk_sys_in, .srst_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in,
      .io_color_sel_in, .io_rdata_out, .io_ack_out, .ul_dword_mode_in, .ul_count_by_4_in, .char_clk_in,
      .hretrace_in, .frame_start_in, .ma_advance_out, .vcount_clk_out, .ma_count_in, .row_scan_in,
      .reorganized_address_out, .decoder_address_in_out, .crt_mode_control_out, .crt_ctrl_run_out, .addr_mode_out);
   crt_far_model u_far (.clk_sys_in, .srst_in, .advance_in(ma_advance_out), .vclk_in(vcount_clk_out), .load_in,
      .load_val_in, .scan_val_in, .ma_count_out(ma_count_in), .row_scan_out(row_scan_in));
   function automatic logic [15:0] exp_reorg(input logic [15:0] m, input logic [7:0] c, input logic dw);
      if (dw) return {m[13:0], m[13], m[12]};
      if (c[6]) return m;
      return c[5] ? {m[14:0], m[15]} : {m[14:0], m[13]};
   endfunction : exp_reorg
   function automatic logic [15:0] exp_dec(input logic [15:0] r, input logic [7:0] c, input logic [4:0] s);
      return {r[15], c[1] ? r[14] : s[1], c[0] ? r[13] : s[0], r[12:0]};
   endfunction : exp_dec
   function automatic logic [1:0] exp_mode(input logic [7:0] c, input logic dw);
      if (dw) return 2'h3;
      if (c[6]) return 2'h0;
      return c[5] ? 2'h2 : 2'h1;
   endfunction : exp_mode
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic io_acc(input logic [15:0] a, input logic wr, input logic [7:0] d, input logic ack);
      @(negedge clk_sys_in);
      io_addr_in <= a;
      io_wr_in <= wr;
      io_rd_in <= !wr;
      io_wdata_in <= d;
      @(negedge clk_sys_in);
      io_wr_in <= 1'b0;
      io_rd_in <= 1'b0;
      chk({15'h0000, io_ack_out}, {15'h0000, ack}, "ack");
      rd_val = io_rdata_out;
   endtask : io_acc
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   initial begin
      #100000;
      fail_count++;
      complete_run;
   end
   initial begin
      repeat (20) @(negedge clk_sys_in);
      srst_in <= 1'b0;
      io_acc(crt_map_pkg::PORT_INDEX_MONO, 1'b1, 8'h17, 1'b1);
      io_acc(crt_map_pkg::PORT_DATA_MONO, 1'b0, 8'h00, 1'b1);
      chk({8'h00, rd_val}, 16'h0000, "reset value");
      io_acc(DTP, 1'b1, 8'hFF, 1'b0);
      io_color_sel_in <= 1'b1;
      // Foreign index: data port still acked, register left alone
      io_acc(IXP, 1'b1, 8'h18, 1'b1);
      io_acc(IXP, 1'b0, 8'h00, 1'b1);
      chk({8'h00, rd_val}, 16'h0018, "index readback");
      io_acc(DTP, 1'b1, 8'hFF, 1'b1);
      io_acc(DTP, 1'b0, 8'h00, 1'b1);
      chk({8'h00, rd_val}, 16'h0000, "foreign index read");
      chk({8'h00, crt_mode_control_out}, 16'h0000, "foreign index write");
      for (int i = 0; i < 64; i++) begin
         seed = xorshift(seed);
         cv = (i < 4) ? {1'b1, i[0], i[1], 5'h03} : seed[7:0];
         io_acc(IXP, 1'b1, 8'h17, 1'b1);
         io_acc(DTP, 1'b1, cv, 1'b1);
         io_acc(DTP, 1'b0, 8'h00, 1'b1);
         chk({8'h00, rd_val}, {8'h00, cv & 8'hEF}, "readback");
         ul_dword_mode_in <= (i < 4) ? 1'b0 : seed[8];
         load_in <= 1'b1;
         load_val_in <= (i < 4) ? corner[i] : seed[31:16];
         scan_val_in <= seed[13:9];
         @(negedge clk_sys_in);
         load_in <= 1'b0;
         chk(reorganized_address_out, exp_reorg(ma_count_in, cv, ul_dword_mode_in), "reorg");
         chk(decoder_address_in_out, exp_dec(exp_reorg(ma_count_in, cv, ul_dword_mode_in), cv, row_scan_in),
             "decoder");
         chk({14'h0000, addr_mode_out}, {14'h0000, exp_mode(cv, ul_dword_mode_in)}, "mode code");
         chk({8'h00, crt_mode_control_out}, {8'h00, cv}, "register");
         chk({15'h0000, crt_ctrl_run_out}, {15'h0000, cv[7]}, "run bit");
      end
      // Back-to-back strobes after a resync
      for (int k = 0; k < 4; k++) begin
         io_acc(IXP, 1'b1, 8'h17, 1'b1);
         io_acc(DTP, 1'b1, {4'h8, k[0], k[0], 2'h3}, 1'b1);
         ul_count_by_4_in <= k[1];
         frame_start_in <= 1'b1;
         @(negedge clk_sys_in);
         frame_start_in <= 1'b0;
         na = 0;
         nv = 0;
         repeat (8) begin
            char_clk_in <= 1'b1;
            hretrace_in <= 1'b1;
            #1;
            na += ma_advance_out;
            nv += vcount_clk_out;
            @(negedge clk_sys_in);
         end
         char_clk_in <= 1'b0;
         hretrace_in <= 1'b0;
         chk(16'(na), k[0] ? 16'h0004 : (k[1] ? 16'h0002 : 16'h0008), "advances");
         chk(16'(nv), k[0] ? 16'h0004 : 16'h0008, "vertical ticks");
      end
      complete_run;
   end
endmodule : crt_refresh_address_mapper_tb_top
`default_nettype wire
